//--- verilog/lsc_pkg.sv
// lsc_pkg: constants, register map and types of the segment lcd controller
package lsc_pkg;

  // geometry of the display buffer
  localparam int          NUM_COM       = 11;
  localparam int          NUM_SEG       = 60;
  localparam int          ROW_BYTES     = 8;
  localparam int          RAM_BYTES     = NUM_COM * ROW_BYTES;
  localparam logic [3:0]  HIGH_NIBBLE_ZERO = 4'h0;

  // register indices; the apb byte address is four times the index
  localparam logic [7:0]  RAM_FIRST_IDX = 8'h00;
  localparam logic [7:0]  RAM_LAST_IDX  = 8'h57;
  localparam logic [7:0]  VLEVEL_IDX    = 8'h5A;
  localparam logic [7:0]  CTRL_IDX      = 8'h70;
  localparam logic [7:0]  SLEEP_IDX     = 8'h7A;
  localparam logic [7:0]  STATUS_IDX    = 8'h7B;
  localparam int          PADDR_W       = 10;
  localparam int          IDX_LSB       = 2;

  // control register fields
  localparam int          CTRL_DUTY_LSB = 0;
  localparam int          CTRL_BIAS_BIT = 2;
  localparam int          CTRL_ON_BIT   = 3;
  localparam logic [3:0]  CTRL_RST      = 4'h0;

  // sleep control fields
  localparam int          SLEEP_STBY_BIT = 0;
  localparam int          SLEEP_LCD_BIT  = 1;

  // status register fields
  localparam int          STAT_COM_LSB  = 4;

  // drive level: reset code and millivolt mapping per bias
  localparam logic [3:0]  VLEVEL_RST    = 4'h7;
  localparam logic [11:0] THIRD_BASE_MV = 12'h960;
  localparam logic [11:0] THIRD_STEP_MV = 12'h03C;
  localparam logic [11:0] QUART_BASE_MV = 12'hA5A;
  localparam logic [11:0] QUART_STEP_MV = 12'h032;

  // multiplex duty codes
  typedef enum logic [1:0] {
    LSC_DUTY_4  = 2'h0,
    LSC_DUTY_8  = 2'h1,
    LSC_DUTY_10 = 2'h2,
    LSC_DUTY_11 = 2'h3
  } lsc_duty_e;

  // system power states, one-hot
  typedef enum logic [2:0] {
    LSC_OPER = 3'h1,
    LSC_HALT = 3'h2,
    LSC_STBY = 3'h4
  } lsc_pwr_e;

  // number of commons scanned for a duty code
  function automatic logic [3:0] lsc_duty_coms(input logic [1:0] code);
    case (code)
      LSC_DUTY_4:  lsc_duty_coms = 4'h4;
      LSC_DUTY_8:  lsc_duty_coms = 4'h8;
      LSC_DUTY_10: lsc_duty_coms = 4'hA;
      default:     lsc_duty_coms = 4'hB;
    endcase
  endfunction

endpackage

//--- verilog/lsc_buf_ram.sv
// lsc_buf_ram: display buffer with a cpu port and a whole-row scan port
`timescale 1ns/1ps
module lsc_buf_ram
  import lsc_pkg::*;
(
  // clock and reset
  input  wire logic                  sys_clk_i,
  input  wire logic                  reset_n_i,
  // cpu port
  input  wire logic                  wr_en_i,
  input  wire logic [6:0]            addr_i,
  input  wire logic [7:0]            wdata_i,
  output logic      [7:0]            rdata_o,
  // scan port
  input  wire logic [3:0]            row_i,
  output logic      [ROW_BYTES*8-1:0] row_data_o
);

  logic [7:0] mem_reg  [RAM_BYTES];
  logic [7:0] mem_next [RAM_BYTES];

  // write path; first byte of a row keeps only its low nibble
  always_comb
  begin
    for (int i = 0; i < RAM_BYTES; i++)
    begin
      mem_next[i] = mem_reg[i];
      if (wr_en_i && (int'(addr_i) == i))
      begin
        mem_next[i] = (i % ROW_BYTES == 0) ? {HIGH_NIBBLE_ZERO, wdata_i[3:0]}
                                           : wdata_i;
      end
    end
  end

  // storage; kept through every power state
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      for (int i = 0; i < RAM_BYTES; i++)
        mem_reg[i] <= 8'h00;
    end
    else
    begin
      for (int i = 0; i < RAM_BYTES; i++)
        mem_reg[i] <= mem_next[i];
    end
  end

  // read ports
  assign rdata_o = mem_reg[addr_i];

  genvar g;
  generate
    for (g = 0; g < ROW_BYTES; g++)
    begin : g_row
      assign row_data_o[(ROW_BYTES-1-g)*8 +: 8] = mem_reg[7'(row_i * ROW_BYTES + g)];
    end
  endgenerate

endmodule

//--- verilog/lsc_scan.sv
// lsc_scan: common sequencer stepping on the low-frequency oscillator
`timescale 1ns/1ps
module lsc_scan
  import lsc_pkg::*;
#(
  parameter int SLOT_TICKS = 4
)
(
  // clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       reset_n_i,
  // control
  input  wire logic       run_i,
  input  wire logic       tick_i,
  input  wire logic [1:0] duty_i,
  // state
  output logic      [3:0] com_idx_o,
  output logic            frame_end_o
);

  logic [7:0] slot_reg;
  logic [7:0] slot_next;
  logic [3:0] com_reg;
  logic [3:0] com_next;
  logic       last_slot;
  logic       last_com;

  assign last_slot   = (slot_reg == 8'(SLOT_TICKS - 1));
  assign last_com    = (com_reg >= lsc_duty_coms(duty_i) - 4'h1);
  assign com_idx_o   = com_reg;
  assign frame_end_o = run_i && tick_i && last_slot && last_com;

  // slot and common counters; wrap at the selected duty
  always_comb
  begin
    slot_next = slot_reg;
    com_next  = com_reg;
    if (!run_i)
    begin
      slot_next = 8'h00;
      com_next  = 4'h0;
    end
    else if (tick_i)
    begin
      slot_next = last_slot ? 8'h00 : slot_reg + 8'h01;
      if (last_slot)
        com_next = last_com ? 4'h0 : com_reg + 4'h1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      slot_reg <= 8'h00;
      com_reg  <= 4'h0;
    end
    else
    begin
      slot_reg <= slot_next;
      com_reg  <= com_next;
    end
  end

endmodule

//--- verilog/lsc_top.sv
// lsc_top: segment lcd controller with apb registers and power states
//
// Overview of operation
// - Scan 4, 8, 10 or 11 commons in turn per the software duty.
// - Each common shows eight buffer bytes; high segments sit in the lowest byte.
// - Upper nibble of each row's first byte is not stored; software avoids it.
// - The panel follows buffer writes with no refresh command.
// - Scan keeps running in halt only when the sleep write sets the display bit; standby stops it.
// - Operating state enables cpu, oscillator, timer and display driver.
// - Sleep control write enters halt or standby; halt keeps oscillator, display optional.
// - Standby stops everything, display and oscillator too; buffer is kept.
// - Port A, counter overflow, 128 Hz or 2 Hz wake resets the cpu.
// - A 4-bit voltage code selects one of sixteen drive levels.
// - Higher code gives higher voltage, from 2.4/2.65 V up to 3.3/3.4 V.
// - Voltage code resets to 07.
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps
module lsc_top
  import lsc_pkg::*;
#(
  parameter int SLOT_TICKS = 4
)
(
  // clock and reset
  input  wire logic               sys_clk_i,
  input  wire logic               reset_n_i,
  // apb slave
  input  wire logic               psel_i,
  input  wire logic               penable_i,
  input  wire logic               pwrite_i,
  input  wire logic [PADDR_W-1:0] paddr_i,
  input  wire logic [31:0]        pwdata_i,
  output logic      [31:0]        prdata_o,
  output logic                    pready_o,
  output logic                    pslverr_o,
  // oscillator and wake sources, asynchronous
  input  wire logic               osc32_i,
  input  wire logic               wake_port_a_i,
  input  wire logic               wake_cnt_ovf_i,
  input  wire logic               wake_tick128_i,
  input  wire logic               wake_tick2_i,
  // power control
  output logic                    cpu_clk_en_o,
  output logic                    osc32_en_o,
  output logic                    timer_en_o,
  output logic                    cpu_reset_o,
  // panel drive
  output logic [NUM_COM-1:0]      com_o,
  output logic [NUM_SEG-1:0]      seg_o,
  output logic                    frame_inv_o,
  output logic                    drv_en_o,
  output logic [3:0]              drv_level_o,
  output logic                    bias_quarter_o,
  output logic [11:0]             panel_drive_voltage_o
);

  // input synchronisers
  logic [4:0] sync1_reg;
  logic [4:0] sync2_reg;
  logic       osc_dly_reg;
  logic       osc_tick;
  logic       any_wake;
  // two flops for each asynchronous input
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      sync1_reg   <= 5'h00;
      sync2_reg   <= 5'h00;
      osc_dly_reg <= 1'b0;
    end
    else
    begin
      sync1_reg   <= {wake_tick2_i, wake_tick128_i, wake_cnt_ovf_i,
                      wake_port_a_i, osc32_i};
      sync2_reg   <= sync1_reg;
      osc_dly_reg <= sync2_reg[0];
    end
  end

  // rising edge of the oscillator gated by its own enable
  assign osc_tick = sync2_reg[0] && !osc_dly_reg && osc32_en_o;
  assign any_wake = |sync2_reg[4:1];

  // apb decode
  logic [7:0] idx;
  logic       hit_ram;
  logic       hit_vlevel;
  logic       hit_ctrl;
  logic       hit_sleep;
  logic       hit_status;
  logic       hit_any;
  logic       apb_done;
  logic       apb_wr;
  logic [7:0] ram_rdata;
  assign idx        = paddr_i[PADDR_W-1:IDX_LSB];
  assign hit_ram    = (idx >= RAM_FIRST_IDX) && (idx <= RAM_LAST_IDX);
  assign hit_vlevel = (idx == VLEVEL_IDX);
  assign hit_ctrl   = (idx == CTRL_IDX);
  assign hit_sleep  = (idx == SLEEP_IDX);
  assign hit_status = (idx == STATUS_IDX);
  assign hit_any    = hit_ram || hit_vlevel || hit_ctrl || hit_sleep || hit_status;
  assign apb_done   = psel_i && penable_i && pready_o;
  assign apb_wr     = apb_done && pwrite_i && hit_any;

  // apb response: one wait state, then a registered answer
  logic        pready_reg;
  logic        pready_next;
  logic        pslverr_reg;
  logic        pslverr_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic [3:0]  ctrl_reg;
  logic [3:0]  vlevel_reg;
  lsc_pwr_e    pwr_reg;
  logic [3:0]  com_idx;
  always_comb
  begin
    pready_next  = psel_i && penable_i && !pready_reg;
    pslverr_next = 1'b0;
    prdata_next  = 32'h0000_0000;
    if (psel_i && penable_i && !pready_reg)
    begin
      pslverr_next = !hit_any;
      if (!pwrite_i)
      begin
        if (hit_ram)
          prdata_next = {24'h00_0000, ram_rdata};
        else if (hit_vlevel)
          prdata_next = {28'h000_0000, vlevel_reg};
        else if (hit_ctrl)
          prdata_next = {28'h000_0000, ctrl_reg};
        else if (hit_status)
          prdata_next = {24'h00_0000, com_idx, 1'b0, pwr_reg};
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end
    else
    begin
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg  <= prdata_next;
    end
  end

  assign pready_o  = pready_reg;
  assign pslverr_o = pslverr_reg;
  assign prdata_o  = prdata_reg;

  // configuration registers
  logic [3:0] ctrl_next;
  logic [3:0] vlevel_next;
  always_comb
  begin
    ctrl_next   = ctrl_reg;
    vlevel_next = vlevel_reg;
    if (apb_wr && hit_ctrl)
      ctrl_next = pwdata_i[3:0];
    if (apb_wr && hit_vlevel)
      vlevel_next = pwdata_i[3:0];
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ctrl_reg   <= CTRL_RST;
      vlevel_reg <= VLEVEL_RST;
    end
    else
    begin
      ctrl_reg   <= ctrl_next;
      vlevel_reg <= vlevel_next;
    end
  end

  // power state machine
  lsc_pwr_e pwr_next;
  logic     halt_lcd_reg;
  logic     halt_lcd_next;
  logic     cpu_rst_reg;
  logic     cpu_rst_next;
  always_comb
  begin
    pwr_next      = pwr_reg;
    halt_lcd_next = halt_lcd_reg;
    cpu_rst_next  = 1'b0;
    case (pwr_reg)
      LSC_OPER:
        if (apb_wr && hit_sleep)
        begin
          pwr_next      = pwdata_i[SLEEP_STBY_BIT] ? LSC_STBY : LSC_HALT;
          halt_lcd_next = pwdata_i[SLEEP_LCD_BIT];
        end
      LSC_HALT, LSC_STBY:
        if (any_wake)
        begin
          pwr_next     = LSC_OPER;
          cpu_rst_next = 1'b1;
        end
      default:
        pwr_next = LSC_OPER;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      pwr_reg      <= LSC_OPER;
      halt_lcd_reg <= 1'b0;
      cpu_rst_reg  <= 1'b0;
    end
    else
    begin
      pwr_reg      <= pwr_next;
      halt_lcd_reg <= halt_lcd_next;
      cpu_rst_reg  <= cpu_rst_next;
    end
  end

  // module enables per state
  logic lcd_on;
  logic oper;
  logic stby;

  assign oper   = (pwr_reg == LSC_OPER);
  assign stby   = (pwr_reg == LSC_STBY);
  assign lcd_on = ctrl_reg[CTRL_ON_BIT] && (oper || (!stby && halt_lcd_reg));

  // buffer and scan
  logic [ROW_BYTES*8-1:0] row_data;
  logic                   frame_end;
  lsc_buf_ram u_buf (
    .sys_clk_i  (sys_clk_i),
    .reset_n_i  (reset_n_i),
    .wr_en_i    (apb_wr && hit_ram),
    .addr_i     (idx[6:0]),
    .wdata_i    (pwdata_i[7:0]),
    .rdata_o    (ram_rdata),
    .row_i      (com_idx),
    .row_data_o (row_data)
  );

  lsc_scan #(
    .SLOT_TICKS (SLOT_TICKS)
  ) u_scan (
    .sys_clk_i   (sys_clk_i),
    .reset_n_i   (reset_n_i),
    .run_i       (lcd_on),
    .tick_i      (osc_tick),
    .duty_i      (ctrl_reg[CTRL_DUTY_LSB +: 2]),
    .com_idx_o   (com_idx),
    .frame_end_o (frame_end)
  );

  // panel outputs, registered every cycle so buffer writes show at once
  logic [NUM_COM-1:0] com_reg;
  logic [NUM_COM-1:0] com_next;
  logic [NUM_SEG-1:0] seg_reg;
  logic [NUM_SEG-1:0] seg_next;
  logic               inv_reg;
  logic               inv_next;
  logic [11:0]        mv_reg;
  logic [11:0]        mv_next;
  logic               gate_reg;
  logic               clk_en_reg;
  logic               osc_en_reg;
  logic               bias_reg;
  logic [3:0]         lvl_reg;
  // one common active at a time
  generate
    for (genvar g = 0; g < NUM_COM; g++)
    begin : g_com
      assign com_next[g] = lcd_on && (int'(com_idx) == g);
    end
  endgenerate

  always_comb
  begin
    seg_next = lcd_on ? row_data[NUM_SEG-1:0] : '0;
    inv_next = lcd_on ? (inv_reg ^ frame_end) : 1'b0;
    if (ctrl_reg[CTRL_BIAS_BIT])
      mv_next = QUART_BASE_MV + 12'(QUART_STEP_MV * vlevel_reg);
    else
      mv_next = THIRD_BASE_MV + 12'(THIRD_STEP_MV * vlevel_reg);
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      com_reg    <= '0;
      seg_reg    <= '0;
      inv_reg    <= 1'b0;
      mv_reg     <= 12'h000;
      gate_reg   <= 1'b0;
      clk_en_reg <= 1'b0;
      osc_en_reg <= 1'b0;
      bias_reg   <= 1'b0;
      lvl_reg    <= VLEVEL_RST;
    end
    else
    begin
      com_reg    <= com_next;
      seg_reg    <= seg_next;
      inv_reg    <= inv_next;
      mv_reg     <= mv_next;
      gate_reg   <= lcd_on;
      clk_en_reg <= oper;
      osc_en_reg <= !stby;
      bias_reg   <= ctrl_reg[CTRL_BIAS_BIT];
      lvl_reg    <= vlevel_reg;
    end
  end

  assign com_o                 = com_reg;
  assign seg_o                 = seg_reg;
  assign frame_inv_o           = inv_reg;
  assign drv_en_o              = gate_reg;
  assign drv_level_o           = lvl_reg;
  assign bias_quarter_o        = bias_reg;
  assign panel_drive_voltage_o = mv_reg;
  assign cpu_clk_en_o          = clk_en_reg;
  assign osc32_en_o            = osc_en_reg;
  assign timer_en_o            = osc_en_reg;
  assign cpu_reset_o           = cpu_rst_reg;

endmodule

//--- dv/lsc_top_checker.sv
// lsc_top_checker: concurrent checks on the ports of the lcd controller
`timescale 1ns/1ps
module lsc_top_checker
  import lsc_pkg::*;
#(
  parameter int SLOT_TICKS = 4
)
(
  // clock, reset and apb
  input wire logic               sys_clk_i,
  input wire logic               reset_n_i,
  input wire logic               psel_i,
  input wire logic               penable_i,
  input wire logic               pwrite_i,
  input wire logic [PADDR_W-1:0] paddr_i,
  input wire logic [31:0]        prdata_o,
  input wire logic               pready_o,
  input wire logic               pslverr_o,
  // wake sources and power control
  input wire logic               wake_port_a_i,
  input wire logic               wake_cnt_ovf_i,
  input wire logic               wake_tick128_i,
  input wire logic               wake_tick2_i,
  input wire logic               cpu_clk_en_o,
  input wire logic               osc32_en_o,
  input wire logic               timer_en_o,
  input wire logic               cpu_reset_o,
  // panel drive
  input wire logic [NUM_COM-1:0] com_o,
  input wire logic [NUM_SEG-1:0] seg_o,
  input wire logic               frame_inv_o,
  input wire logic               drv_en_o,
  input wire logic [3:0]         drv_level_o,
  input wire logic               bias_quarter_o,
  input wire logic [11:0]        panel_drive_voltage_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  // sleep write completing, and any wake source raised
  wire logic        sleep_wr = psel_i && penable_i && pready_o && pwrite_i
                               && paddr_i[9:2] == SLEEP_IDX;
  wire logic        wake_any = wake_port_a_i || wake_cnt_ovf_i || wake_tick128_i
                               || wake_tick2_i;
  // expected millivolts: 2400 + 60 per code, or 2650 + 50 per code
  wire logic [11:0] mv_exp   = bias_quarter_o ? 12'hA5A + 12'h032 * drv_level_o
                                              : 12'h960 + 12'h03C * drv_level_o;

  // apb answer after one wait state, one cycle wide
  a_ready_one_wait: assert property (psel_i && !penable_i |=> !pready_o ##1 pready_o)
    else $error("pready not in second access cycle");
  a_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("pready longer than one cycle");
  a_err_zero: assert property (pslverr_o |-> pready_o && prdata_o == '0)
    else $error("error answer without ready or with data");
  // scan and drive level
  a_com_onehot: assert property ($onehot0(com_o))
    else $error("more than one common active");
  a_on_scan: assert property (drv_en_o |-> $onehot(com_o))
    else $error("no single common while display on");
  a_off_blank: assert property (!drv_en_o |-> com_o == '0 && seg_o == '0 && !frame_inv_o)
    else $error("panel driven while display off");
  a_inv_frame: assert property (drv_en_o && $changed(frame_inv_o)
    |=> !drv_en_o || com_o[0])
    else $error("frame inversion away from a frame start");
  a_volt_map: assert property ($past(reset_n_i) && $stable(drv_level_o)
    && $stable(bias_quarter_o) |-> panel_drive_voltage_o == mv_exp)
    else $error("drive voltage does not match code and bias");
  // power states
  a_sleep_clk: assert property (sleep_wr && cpu_clk_en_o && !wake_any |-> ##2 !cpu_clk_en_o)
    else $error("cpu clock still on after sleep write");
  a_wake_reset: assert property (cpu_reset_o |=> !cpu_reset_o && cpu_clk_en_o)
    else $error("wake reset pulse wrong");
  a_stby_off: assert property (!osc32_en_o [*2] |-> com_o == '0 && !cpu_clk_en_o)
    else $error("display or cpu active in standby");
  a_run_osc: assert property (osc32_en_o == timer_en_o && (!cpu_clk_en_o || osc32_en_o))
    else $error("oscillator or timer off while operating");

  // main scenarios reached
  c_sleep: cover property (sleep_wr);
  c_wake: cover property (cpu_reset_o);
  c_com11: cover property (com_o[NUM_COM-1]);
  c_top_level: cover property (bias_quarter_o && drv_level_o == 4'hF);
endmodule

bind lsc_top lsc_top_checker #(.SLOT_TICKS(SLOT_TICKS)) u_checker (.*);

//--- dv/lsc_panel_model.sv
// lsc_panel_model: glass panel that records the row shown on each common
`timescale 1ns/1ps
module lsc_panel_model
  import lsc_pkg::*;
(
  // clock and capture clear
  input  wire logic               sys_clk_i,
  input  wire logic               clear_i,
  // common and segment drive
  input  wire logic [NUM_COM-1:0] com_i,
  input  wire logic [NUM_SEG-1:0] seg_i,
  // what the glass has shown
  output logic      [NUM_COM-1:0] seen_o,
  output logic      [NUM_SEG-1:0] rows_o [NUM_COM]
);
  // latch the segment pattern of each common while it is driven
  always @(posedge sys_clk_i)
  begin
    if (clear_i)
      seen_o <= '0;
    for (int c = 0; c < NUM_COM; c++)
      if (com_i[c] && !clear_i)
      begin
        seen_o[c] <= 1'h1;
        rows_o[c] <= seg_i;
      end
  end
endmodule

//--- dv/lsc_top_bench.sv
// lsc_top_bench: self-checking bench for the segment lcd controller
`timescale 1ns/1ps
module lsc_top_bench;
  import lsc_pkg::*;
  localparam int         SLOT = 1;
  localparam logic [1:0] SLP [4] = '{2'h2, 2'h0, 2'h1, 2'h3};
  logic                sys_clk_i = 0, reset_n_i = 0, osc32_i = 0, clr = 0, q, err;
  logic                psel_i = 0, penable_i = 0, pwrite_i = 0, pready_o, pslverr_o;
  logic [PADDR_W-1:0]  paddr_i = '0;
  logic [31:0]         pwdata_i = '0, prdata_o, rd;
  logic [3:0]          wake = '0, drv_level_o;
  logic                cpu_clk_en_o, osc32_en_o, timer_en_o, cpu_reset_o;
  logic                frame_inv_o, drv_en_o, bias_quarter_o;
  logic [NUM_COM-1:0]  com_o, seen;
  logic [NUM_SEG-1:0]  seg_o, rows [NUM_COM];
  logic [11:0]         panel_drive_voltage_o;
  logic [7:0]          mem [RAM_BYTES], d;
  int                  n_errors = 0, cmp_count = 0, cyc = 0, n, seed = 32'h8F80;

  // device and glass
  lsc_top #(.SLOT_TICKS(SLOT)) DUT (.*, .wake_port_a_i(wake[0]), .wake_cnt_ovf_i(wake[1]),
    .wake_tick128_i(wake[2]), .wake_tick2_i(wake[3]));
  lsc_panel_model PANEL (.sys_clk_i(sys_clk_i), .clear_i(clr), .com_i(com_o),
    .seg_i(seg_o), .seen_o(seen), .rows_o(rows));

  always #20 sys_clk_i = ~sys_clk_i;
  // sped-up oscillator that stops while disabled, plus the run limit
  always @(posedge sys_clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc % 5 == 4 && osc32_en_o)
      osc32_i <= ~osc32_i;
    if (cyc == 12000)
    begin
      n_errors = n_errors + 1;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [63:0] ex, input logic [63:0] got);
    cmp_count++;
    if (got !== ex)
    begin
      n_errors++;
      $display("Error %s expected %0h seen %0h", nm, ex, got);
    end
  endtask

  // one apb transfer; waits for pready and keeps data and error flag
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    @(posedge sys_clk_i);
    psel_i <= 1'h1;
    pwrite_i <= wr;
    paddr_i <= {idx, 2'h0};
    pwdata_i <= wd;
    @(posedge sys_clk_i);
    penable_i <= 1'h1;
    do
      @(posedge sys_clk_i);
    while (pready_o !== 1'h1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'h0;
    penable_i <= 1'h0;
  endtask

  // clear the glass record and let three frames pass
  task automatic watch();
    @(posedge sys_clk_i);
    clr <= 1'h1;
    @(posedge sys_clk_i);
    clr <= 1'h0;
    repeat (30 * NUM_COM * SLOT) @(posedge sys_clk_i);
  endtask

  // expected glass row: byte 8r+7 holds the lowest segments
  function automatic logic [59:0] exp_row(int r);
    exp_row[59:56] = mem[8*r][3:0];
    for (int j = 1; j < 8; j++)
      exp_row[(7-j)*8 +: 8] = mem[8*r+j];
  endfunction

  function automatic logic [11:0] exp_mv(logic [3:0] c, logic qb);
    exp_mv = qb ? 12'hA5A + 12'h032 * c : 12'h960 + 12'h03C * c;
  endfunction

  function automatic int ncom(int dt);
    ncom = dt == 0 ? 4 : dt == 1 ? 8 : dt + 8;
  endfunction

  initial
  begin
    repeat (5) @(posedge sys_clk_i);
    reset_n_i <= 1'h1;
    // reset values
    apb(1'h0, VLEVEL_IDX, '0);
    chk("vlevel_rst", 64'h7, rd);
    chk("mv_rst", 64'hB04, panel_drive_voltage_o);
    apb(1'h0, CTRL_IDX, '0);
    chk("ctrl_rst", 64'h0, rd);
    apb(1'h0, STATUS_IDX, '0);
    chk("status_rst", 64'h1, rd);
    // all sixteen codes under a random bias
    for (int c = 0; c < 16; c++)
    begin
      q = 1'($random(seed));
      apb(1'h1, CTRL_IDX, {29'h0, q, 2'h0});
      apb(1'h1, VLEVEL_IDX, 32'(c));
      apb(1'h0, VLEVEL_IDX, '0);
      chk("vlevel", 64'(c), rd);
      chk("mv", exp_mv(c[3:0], q), panel_drive_voltage_o);
    end
    // fill the buffer, first byte of a row with a set upper nibble
    for (int i = 0; i < RAM_BYTES; i++)
    begin
      d = 8'($random(seed));
      if (i % 8 == 0)
        d[7:4] = 4'hF;
      mem[i] = (i % 8 == 0) ? {4'h0, d[3:0]} : d;
      apb(1'h1, 8'(i), {24'h0, d});
    end
    for (int i = 0; i < RAM_BYTES; i++)
    begin
      apb(1'h0, 8'(i), '0);
      chk("ram", 64'(mem[i]), rd);
    end
    apb(1'h1, 8'h60, 32'hFF);
    apb(1'h0, 8'h60, '0);
    chk("unmapped", 64'h1_0000_0000, {err, rd});
    // every duty, display on
    for (int dt = 0; dt < 4; dt++)
    begin
      apb(1'h1, CTRL_IDX, 32'h8 | dt);
      watch();
      chk("commons", (64'h1 << ncom(dt)) - 1, seen);
      for (int r = 0; r < ncom(dt); r++)
        chk("row", exp_row(r), rows[r]);
    end
    d = 8'($random(seed));
    mem[RAM_LAST_IDX] = d;
    apb(1'h1, RAM_LAST_IDX, {24'h0, d});
    watch();
    chk("row_update", exp_row(10), rows[10]);
    // halt with and without display, standby, each woken by another source
    for (int i = 0; i < 4; i++)
    begin
      apb(1'h1, SLEEP_IDX, {30'h0, SLP[i]});
      watch();
      chk("cpu_clk", 64'h0, cpu_clk_en_o);
      chk("osc_en", !SLP[i][0], osc32_en_o);
      chk("scan", SLP[i] == 2'h2 ? 64'h7FF : 64'h0, seen);
      chk("drv_en", SLP[i] == 2'h2, drv_en_o);
      apb(1'h0, STATUS_IDX, '0);
      chk("state", SLP[i][0] ? 64'h4 : 64'h2, rd[2:0]);
      wake[i] <= 1'h1;
      n = 0;
      while (cpu_reset_o !== 1'h1 && n < 20)
      begin
        @(posedge sys_clk_i);
        n++;
      end
      chk("wake", 64'h1, cpu_reset_o);
      @(posedge sys_clk_i);
      wake <= '0;
      chk("cpu_run", 64'h1, {cpu_clk_en_o & osc32_en_o});
      repeat (6) @(posedge sys_clk_i);
    end
    // buffer kept through standby
    for (int i = 0; i < 8; i++)
    begin
      apb(1'h0, 8'(i), '0);
      chk("ram_kept", 64'(mem[i]), rd);
    end
    stop_test();
  end
endmodule
